//--- wct_pkg.sv
/*
 * Constants, register map and state type for the wakeup countdown timer.
 * Assumes a 20 MHz system clock and a register port with byte addresses.
 */
package wct_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int BASE_TICK_HZ = 4096;
	// Integer divide; the base tick runs about 0.017 percent fast
	localparam int DIV_4096 = CLK_HZ / BASE_TICK_HZ;
	localparam int REL_SHORT_NS = 122_000;
	localparam int REL_LONG_NS = 7_813_000;
	localparam int REL_SHORT_CYC = (REL_SHORT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int REL_LONG_CYC = (REL_LONG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int DIV64_LAST = 63;
	localparam int DIV1_LAST = 4095;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLAG = 8'h04;
	localparam logic [7:0] OFS_PRESET = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0C;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int B_SEL_LO = 0;
	localparam int B_SEL_HI = 1;
	localparam int B_ENABLE = 4;
	localparam int B_IRQ_EN = 5;
	localparam int B_PAUSE_N = 6;
	localparam int B_RELOAD = 7;
	localparam int B_FLAG = 0;
	localparam int B_IRQ_ACT = 1;
	localparam int B_PIN_LVL = 2;
	localparam logic [1:0] SEL_4096 = 2'h0;
	localparam logic [1:0] SEL_64 = 2'h1;
	localparam logic [1:0] SEL_1HZ = 2'h2;
	localparam logic [1:0] SEL_MIN = 2'h3;
	localparam logic [1:0] RST_SEL = SEL_1HZ;
	localparam logic RST_PAUSE_N = 1'b1;
	localparam logic [23:0] RST_PRESET = 24'h00_0000;
	localparam int PRESET_W = 24;

	// ----------------------------------------
	// Run state
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ARMED = 4'b0010,
		ST_LOAD = 4'b0100,
		ST_COUNT = 4'b1000
	} wct_state_t;

endpackage

//--- wct_tick_gen.sv
/*
 * Free running source ticks at 4096 Hz, 64 Hz and 1 Hz, one-cycle pulses.
 * Assumes a system clock of DIV_4096 times 4096 Hz.
 */
module wct_tick_gen #(
	parameter int DIV_4096 = wct_pkg::DIV_4096
) (
	input wire logic clk,
	input wire logic reset,
	output logic tick_4096,
	output logic tick_64,
	output logic tick_1
);

	localparam int DW = $clog2(DIV_4096);

	logic [DW-1:0] div_r;
	logic [11:0] sub_r;
	wire base = (div_r == DW'(DIV_4096 - 1));
	wire last64 = (sub_r[5:0] == 6'(wct_pkg::DIV64_LAST));
	wire last1 = (sub_r == 12'(wct_pkg::DIV1_LAST));

	generate
		if (DIV_4096 < 2) begin : g_chk
			$error("DIV_4096 must be at least 2");
		end
	endgenerate

	// ----------------------------------------
	// Dividers
	// ----------------------------------------
	// The 1 Hz tick is free and not tied to any calendar seconds update
	always_ff @(posedge clk) begin
		if (reset) begin
			div_r <= '0;
			sub_r <= 12'h000;
			tick_4096 <= 1'b0;
			tick_64 <= 1'b0;
			tick_1 <= 1'b0;
		end else begin
			div_r <= base ? '0 : div_r + DW'(1);
			sub_r <= base ? sub_r + 12'h001 : sub_r;
			tick_4096 <= base;
			tick_64 <= base & last64;
			tick_1 <= base & last1;
		end
	end

endmodule

//--- wct_wakeup_timer.sv
/*
 * Wakeup countdown timer: 24-bit preset counted down on a selectable source,
 * sticky event flag and open-drain shared interrupt with automatic release.
 * Assumes a register port master on clk, an asynchronous serial clock pin
 * and a minute update pulse from calendar logic on clk.
 */
module wct_wakeup_timer #(
	parameter int DIV_4096 = wct_pkg::DIV_4096,
	parameter int REL_SHORT_CYC = wct_pkg::REL_SHORT_CYC,
	parameter int REL_LONG_CYC = wct_pkg::REL_LONG_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire logic scl,
	input wire logic minute_tick,
	input wire logic int_in,
	output logic int_out,
	output logic int_oe_n
);

	localparam int RW = $clog2(REL_LONG_CYC + 1);
	localparam int PW = wct_pkg::PRESET_W;

	generate
		if (REL_SHORT_CYC < 1 || REL_SHORT_CYC > REL_LONG_CYC) begin : g_chk
			$error("Release counts must satisfy 1 <= short <= long");
		end
	endgenerate

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Register match, shared by the write decode and the read mux
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// Only the fast source has the short release time
	function automatic logic sel_fast(input logic [1:0] sel);
		return sel == wct_pkg::SEL_4096;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [1:0] sel_r;
	logic enable_r;
	logic irq_en_r;
	logic pause_n_r;
	logic flag_r;
	logic irq_act_r;
	logic [PW-1:0] preset_r;
	logic [PW-1:0] cnt_r;
	logic [RW-1:0] rel_r;
	wct_pkg::wct_state_t state_r;
	logic scl_s1_r;
	logic scl_s2_r;
	logic scl_s3_r;
	logic pin_s1_r;
	logic pin_s2_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire ctrl_wr = wr_en & reg_hit(addr, wct_pkg::OFS_CTRL);
	wire flag_wr = wr_en & reg_hit(addr, wct_pkg::OFS_FLAG);
	wire preset_wr = wr_en & reg_hit(addr, wct_pkg::OFS_PRESET);
	wire flag_clr = flag_wr & ~wdata[wct_pkg::B_FLAG];
	wire [1:0] sel_nxt = ctrl_wr ? wdata[wct_pkg::B_SEL_HI:wct_pkg::B_SEL_LO] : sel_r;
	wire enable_nxt = ctrl_wr ? wdata[wct_pkg::B_ENABLE] : enable_r;
	wire irq_en_nxt = ctrl_wr ? wdata[wct_pkg::B_IRQ_EN] : irq_en_r;
	wire pause_n_nxt = ctrl_wr ? wdata[wct_pkg::B_PAUSE_N] : pause_n_r;
	wire reload = ctrl_wr & wdata[wct_pkg::B_RELOAD];
	wire [PW-1:0] preset_nxt = preset_wr ? wdata[PW-1:0] : preset_r;
	wire en_start = ~enable_r & enable_nxt;
	// Edge of the serial clock taken from the second and third stages only
	wire scl_rise = scl_s2_r & ~scl_s3_r;

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	logic tick_4096;
	logic tick_64;
	logic tick_1;

	wct_tick_gen #(
		.DIV_4096(DIV_4096)
	) u_ticks (
		.clk(clk),
		.reset(reset),
		.tick_4096(tick_4096),
		.tick_64(tick_64),
		.tick_1(tick_1)
	);

	wire src_tick = sel_fast(sel_r) ? tick_4096 :
		(sel_r == wct_pkg::SEL_64) ? tick_64 :
		(sel_r == wct_pkg::SEL_1HZ) ? tick_1 : minute_tick;
	wire preset_nz = (preset_r != '0);
	wire tick_ok = src_tick & pause_n_r & preset_nz;
	wire counting = (state_r == wct_pkg::ST_COUNT) & enable_r;
	wire wake_evt = counting & tick_ok & ~reload & (cnt_r == PW'(1));

	// ----------------------------------------
	// Run state
	// ----------------------------------------
	wct_pkg::wct_state_t state_nxt;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			wct_pkg::ST_IDLE: begin
				if (en_start) begin
					state_nxt = wct_pkg::ST_ARMED;
				end
			end
			wct_pkg::ST_ARMED: begin
				if (scl_rise) begin
					state_nxt = wct_pkg::ST_LOAD;
				end
			end
			wct_pkg::ST_LOAD: begin
				if (tick_ok) begin
					state_nxt = wct_pkg::ST_COUNT;
				end
			end
			wct_pkg::ST_COUNT: begin
				state_nxt = wct_pkg::ST_COUNT;
			end
			default: begin
				state_nxt = wct_pkg::ST_IDLE;
			end
		endcase
		if (!enable_nxt) begin
			state_nxt = wct_pkg::ST_IDLE;
		end
	end

	// ----------------------------------------
	// Down counter
	// ----------------------------------------
	logic [PW-1:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (!counting) begin
			cnt_nxt = preset_r;
		end else if (reload) begin
			cnt_nxt = preset_r;
		end else if (tick_ok) begin
			cnt_nxt = (cnt_r <= PW'(1)) ? preset_r : cnt_r - PW'(1);
		end
	end

	// ----------------------------------------
	// Flag and interrupt
	// ----------------------------------------
	// write one ignored
	wire flag_nxt = wake_evt | (flag_r & ~flag_clr);
	wire [RW-1:0] rel_load = sel_fast(sel_r) ? RW'(REL_SHORT_CYC) :
		RW'(REL_LONG_CYC);
	wire rel_done = irq_act_r & (rel_r == RW'(1));
	// Counts only while the pin is held; a new event restarts it
	wire [RW-1:0] rel_nxt = wake_evt ? rel_load :
		(irq_act_r ? rel_r - RW'(1) : rel_r);
	logic irq_nxt;

	always_comb begin
		irq_nxt = irq_act_r;
		if (!irq_en_nxt || !enable_nxt) begin
			irq_nxt = 1'b0;
		end else if (wake_evt) begin
			irq_nxt = 1'b1;
		end else if (rel_done) begin
			irq_nxt = 1'b0;
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire [31:0] ctrl_rd = {24'h00_0000, 1'b0, pause_n_r, irq_en_r, enable_r, 2'b00, sel_r};
	wire [31:0] flag_rd = {29'h0000_0000, pin_s2_r, irq_act_r, flag_r};
	wire [31:0] rd_mux = reg_hit(addr, wct_pkg::OFS_CTRL) ? ctrl_rd :
		reg_hit(addr, wct_pkg::OFS_FLAG) ? flag_rd :
		reg_hit(addr, wct_pkg::OFS_PRESET) ? {8'h00, preset_r} :
		reg_hit(addr, wct_pkg::OFS_COUNT) ? {8'h00, cnt_r} : 32'h0000_0000;

	// ----------------------------------------
	// State update
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			sel_r <= wct_pkg::RST_SEL;
			enable_r <= 1'b0;
			irq_en_r <= 1'b0;
			pause_n_r <= wct_pkg::RST_PAUSE_N;
			preset_r <= wct_pkg::RST_PRESET;
			state_r <= wct_pkg::ST_IDLE;
		end else begin
			sel_r <= sel_nxt;
			enable_r <= enable_nxt;
			irq_en_r <= irq_en_nxt;
			pause_n_r <= pause_n_nxt;
			preset_r <= preset_nxt;
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= wct_pkg::RST_PRESET;
			flag_r <= 1'b0;
			irq_act_r <= 1'b0;
			rel_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			flag_r <= flag_nxt;
			irq_act_r <= irq_nxt;
			rel_r <= rel_nxt;
		end
	end

	// Pins come from outside the clock domain, so two stages before use
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_s3_r <= 1'b1;
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
		end else begin
			scl_s1_r <= scl;
			scl_s2_r <= scl_s1_r;
			scl_s3_r <= scl_s2_r;
			pin_s1_r <= int_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 32'h0000_0000;
			int_out <= 1'b0;
			int_oe_n <= 1'b1;
		end else begin
			rdata <= rd_en ? rd_mux : 32'h0000_0000;
			int_out <= 1'b0;
			int_oe_n <= ~irq_nxt;
		end
	end

endmodule

//--- wct_assertions.sv
/* Port checker for the wakeup timer.
   Bound to wct_wakeup_timer; sees only its ports. */
module wct_chk #(
	parameter int REL_SHORT_CYC = wct_pkg::REL_SHORT_CYC,
	parameter int REL_LONG_CYC = wct_pkg::REL_LONG_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [31:0] rdata,
	input wire logic int_out,
	input wire logic int_oe_n
);
	// ----
	// Helpers
	// ----
	logic [7:0] ctrl_r;
	int low_cnt_r;
	int rel_exp;
	wire ctrl_wr = wr_en && addr == wct_pkg::OFS_CTRL;
	wire flag_clr = wr_en && addr == wct_pkg::OFS_FLAG && !wdata[0];
	assign rel_exp = (ctrl_r[1:0] == wct_pkg::SEL_4096) ? REL_SHORT_CYC : REL_LONG_CYC;
	// Mirror of control; a mid-pulse select change would confuse it
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_r <= 8'h42;
		end else if (ctrl_wr) begin
			ctrl_r <= wdata[7:0];
		end
	end
	always_ff @(posedge clk) begin
		if (reset || int_oe_n) begin
			low_cnt_r <= 0;
		end else begin
			low_cnt_r <= low_cnt_r + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ----
	// Properties
	// ----
	// drives low only
	property p_drive_low; int_out == 1'b0; endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("int_out not low");
	property p_irq_off; ctrl_wr && !wdata[5] |=> int_oe_n; endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("pin held after irq disable");
	property p_en_off; ctrl_wr && !wdata[4] |=> int_oe_n; endproperty
	a_en_off: assert property (p_en_off)
		else $error("pin held after timer disable");
	property p_fall_irq; $fell(int_oe_n) |-> ctrl_r[5]; endproperty
	a_fall_irq: assert property (p_fall_irq)
		else $error("pin pulled with irq disabled");
	property p_fall_en; $fell(int_oe_n) |-> ctrl_r[4]; endproperty
	a_fall_en: assert property (p_fall_en)
		else $error("pin pulled while disabled");
	property p_rel_len; $rose(int_oe_n) && !$past(ctrl_wr) |-> low_cnt_r == rel_exp; endproperty
	a_rel_len: assert property (p_rel_len)
		else $error("release time wrong");
	property p_clr_hold; flag_clr && !int_oe_n && low_cnt_r + 2 < rel_exp |=> !int_oe_n;
	endproperty
	a_clr_hold: assert property (p_clr_hold)
		else $error("flag clear released pin");
	property p_reload_rd; rd_en && addr == wct_pkg::OFS_CTRL |=> !rdata[7]; endproperty
	a_reload_rd: assert property (p_reload_rd)
		else $error("reload bit reads one");
endmodule

bind wct_wakeup_timer wct_chk #(
	.REL_SHORT_CYC(REL_SHORT_CYC),
	.REL_LONG_CYC(REL_LONG_CYC)
) i_wct_chk (
	.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .int_out(int_out), .int_oe_n(int_oe_n)
);

//--- wct_host_model.sv
/* Serial host and shared interrupt wire.
   A rising go starts one serial frame; scl idles high between frames. */
module wct_host_model (
	input wire logic go,
	input wire logic int_oe_n,
	input wire logic other_low,
	output logic scl,
	output logic int_wire
);
	timeunit 1ns;
	timeprecision 1ns;
	assign int_wire = !(!int_oe_n || other_low);
	// clock after the write
	// A go during a running frame is lost; that frame's edges still start the timer
	initial begin
		scl = 1'b1;
		forever begin
			@(posedge go);
			#37;
			repeat (9) begin
				scl = 1'b0;
				#200;
				scl = 1'b1;
				#200;
			end
		end
	end
endmodule

//--- tb_top.sv
/* Self-checking bench for the wakeup timer.
   Needs wct_pkg, the design, wct_host_model and wct_chk. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIV = 4;
	localparam int RS = 3;
	localparam int RL = 8;
	logic clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, minute_tick = 1'b0;
	logic go = 1'b0, other_low = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic scl, int_in, int_out, int_oe_n;
	// Seed 28771
	logic [15:0] rnd = 16'h7063;
	int errors = 0, check_count = 0, cyc = 0, n, g, p;
	int exp_q[$];
	// Source periods in cycles; minute pulses every 300
	int per[4] = '{DIV, DIV * 64, DIV * 4096, 300};

	always #25 clk = ~clk;
	wct_wakeup_timer #(.DIV_4096(DIV), .REL_SHORT_CYC(RS), .REL_LONG_CYC(RL)) i_wct_wakeup_timer (
		.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .scl(scl), .minute_tick(minute_tick), .int_in(int_in),
		.int_out(int_out), .int_oe_n(int_oe_n));
	wct_host_model i_wct_host_model (.go(go), .int_oe_n(int_oe_n), .other_low(other_low),
		.scl(scl), .int_wire(int_in));

	// ----
	// Tasks
	// ----
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Model: count after k qualified ticks from a full preset, reload from one
	function automatic int model_cnt(input int pre, input int k);
		return (pre == 0) ? 0 : pre - (k % pre);
	endfunction
	task automatic summarize;
		$display("Checks %0d, errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask
	task automatic wfall(output int c);
		c = 0;
		while (int_oe_n !== 1'b0 && c < 40000) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask
	task automatic start(input logic [31:0] pre, input logic [7:0] ctl);
		wr(wct_pkg::OFS_CTRL, 32'h0);
		chk(32'(int_oe_n), 32'h1);
		wr(wct_pkg::OFS_FLAG, 32'h0);
		wr(wct_pkg::OFS_PRESET, pre);
		wr(wct_pkg::OFS_CTRL, 32'(ctl));
		rc(wct_pkg::OFS_COUNT, '1, pre);
		// No serial clock edge yet, so nothing may have been counted
		repeat (16) @(posedge clk);
		rc(wct_pkg::OFS_FLAG, 32'h1, 32'h0);
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		minute_tick <= (cyc % 300 == 299);
		if (cyc == 80000) begin
			errors++;
			$display("ERROR %0t: timeout", $time);
			summarize();
		end
	end

	// ----
	// Sequence
	// ----
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rc(wct_pkg::OFS_CTRL, '1, 32'h0000_0042);
		rc(wct_pkg::OFS_FLAG, '1, 32'h0000_0004);
		rc(wct_pkg::OFS_COUNT, '1, 32'h0);
		rc(8'h10, '1, 32'h0);
		$display("Test reset done");
		for (int s = 0; s < 4; s++) begin
			rnd = nxt(rnd);
			p = (s == 2) ? 1 : 1 + int'(rnd % 3);
			start(p, 8'h70 | 8'(s));
			exp_q.push_back(p * per[s]);
			wfall(n);
			n = 0;
			while (int_oe_n === 1'b0) begin
				@(posedge clk);
				#1;
				n++;
			end
			chk(n, (s == 0) ? RS : RL);
			wfall(g);
			chk(n + g, exp_q.pop_front());
			rc(wct_pkg::OFS_FLAG, 32'h1, 32'h1);
			$display("Test select %0d done", s);
		end
		start(32'h5, 8'h71);
		wfall(n);
		wr(wct_pkg::OFS_FLAG, 32'h0);
		chk(32'(int_oe_n), 32'h0);
		wr(wct_pkg::OFS_CTRL, 32'h51);
		chk(32'(int_oe_n), 32'h1);
		// Two 64 Hz periods of 256 cycles pass, the third is still ahead
		repeat (600) @(posedge clk);
		rc(wct_pkg::OFS_COUNT, '1, model_cnt(5, 2));
		wr(wct_pkg::OFS_CTRL, 32'h91);
		rc(wct_pkg::OFS_COUNT, '1, model_cnt(5, 0));
		repeat (600) @(posedge clk);
		rc(wct_pkg::OFS_COUNT, '1, 32'h5);
		wr(wct_pkg::OFS_FLAG, 32'h1);
		rc(wct_pkg::OFS_FLAG, 32'h1, 32'h0);
		$display("Test pause and reload done");
		start(32'h1, 8'h50);
		repeat (100) @(posedge clk);
		rc(wct_pkg::OFS_FLAG, 32'h7, 32'h5);
		other_low <= 1'b1;
		repeat (4) @(posedge clk);
		rc(wct_pkg::OFS_FLAG, 32'h4, 32'h0);
		other_low <= 1'b0;
		start(32'h0, 8'h70);
		repeat (100) @(posedge clk);
		rc(wct_pkg::OFS_FLAG, 32'h3, 32'h0);
		$display("Test masked and zero preset done");
		summarize();
	end
endmodule
